// file: adcsc_host_model.sv
// serial master model: frames, clocks bytes and drives the comparator pin
// assumes the device lags pin edges by its synchroniser, so dout is read late
`timescale 1ns/100ps
module adcsc_host_model (
  // clock
  input wire logic clock,
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout,
  // analog side stand-in
  output logic comparator_in
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    comparator_in = 1'b0;
  end
  // deselected din shows no stale level
  always @(posedge clock) if (cs_n) din <= ~din;
  task automatic frame(input logic low);
    @(posedge clock);
    cs_n <= !low;
    repeat (8) @(posedge clock);
  endtask
  // clock idles low, din set after falls, read late in high phase
  // 80 ns clock keeps every frame far inside the droop limits
  task automatic xfer(input logic [7:0] tx, input logic [7:0] cmp, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clock);
      sclk <= 1'b0;
      din <= tx[i];
      repeat (i == 7 ? 3 : 4) @(posedge clock); // byte gap would stretch the period
      sclk <= 1'b1;
      comparator_in <= cmp[i];
      repeat (3) @(posedge clock);
      @(negedge clock);
      rx[i] = dout;
    end
    @(posedge clock);
    sclk <= 1'b0;
  endtask
endmodule // adcsc_host_model

// file: adcsc_pkg.sv
// constants, types and timing figures of the serial conversion sequencer
// assumes a 100 MHz system clock; all pins arrive asynchronously
package adcsc_pkg;
  // synchroniser lanes
  localparam int ADCSC_NSYNC = 6;
  localparam int SY_CS = 0;
  localparam int SY_SCLK = 1;
  localparam int SY_DIN = 2;
  localparam int SY_SHUTDOWN_INPUT = 3;
  localparam int SY_COMP = 4;
  localparam int SY_OSC = 5;
  // control byte layout
  localparam int CTRL_BITS = 8;
  localparam int CB_SEL_HI = 6;
  localparam int CB_SEL_LO = 4;
  localparam int CB_POL = 3;
  localparam int CB_CFG = 2;
  localparam int CB_PD1 = 1;
  localparam int CB_PD0 = 0;
  localparam logic [3:0] RX_LAST = 4'h8;
  localparam logic [3:0] RX_ACQ_FIRST = 4'h5;
  localparam logic [3:0] RX_ONE = 4'h1;
  // mode bits
  localparam logic [1:0] MODE_EXT = 2'h3;
  localparam logic [1:0] MODE_INT = 2'h2;
  localparam logic [1:0] MODE_FAST_PD = 2'h1;
  localparam logic [1:0] MODE_FULL_PD = 2'h0;
  // result framing, counted in serial clock falls or conversion clocks
  localparam int RES_BITS = 12;
  localparam logic [4:0] EXT_RES_LAST = 5'h0c;
  localparam logic [4:0] EXT_B3_FALL = 5'h09;
  localparam logic [4:0] EXT_FALL_LAST = 5'h0f;
  localparam logic [4:0] RD_B3_FALL = 5'h08;
  localparam logic [4:0] RD_LAST = 5'h0b;
  localparam logic [4:0] SAR_LAST = 5'h0b;
  localparam logic [4:0] CNT_ONE = 5'h01;
  // power-on wait
  localparam int CLK_FREQ_MHZ = 100;
  localparam int POR_TIME_US = 100;
  localparam int POR_CYCLES = POR_TIME_US * CLK_FREQ_MHZ;
  // result buffer
  localparam int FIFO_DEPTH = 32;
  typedef enum logic [1:0] {ST_HUNT, ST_EXT, ST_INT, ST_READ} adcsc_state_t;
endpackage

// file: adcsc_tb_top.sv
// self-checking bench for the serial conversion sequencer
// assumes 100 MHz clock; the host model drives the serial pins
`timescale 1ns/100ps
module adcsc_tb_top import adcsc_pkg::*; ;
  logic clock, srst, shutdown_input_n, osc_in, result_ready, ext;
  logic cs_n, sclk, din, dout, dout_oe, conversion_strobe_out, conversion_strobe_oe;
  logic comparator_in, polarity_select, input_config_select, ext_clock_mode;
  logic quick_power_down, complete_power_down, acquisition_active, converting, result_valid;
  logic [2:0] channel_select;
  logic [RES_BITS-1:0] result_data;
  logic [11:0] exp_q[$];
  int n_fail = 0;
  int n_compared = 0;
  int seed = 61;
  int osc_half;
  adcsc_top #(.POR_WAIT(20), .DEPTH(FIFO_DEPTH)) adcsc_top_inst (
    .clock(clock), .srst(srst), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe(dout_oe), .conversion_strobe_out(conversion_strobe_out),
    .conversion_strobe_oe(conversion_strobe_oe), .shutdown_input_n(shutdown_input_n),
    .comparator_in(comparator_in), .osc_in(osc_in), .channel_select(channel_select),
    .polarity_select(polarity_select), .input_config_select(input_config_select),
    .ext_clock_mode(ext_clock_mode), .quick_power_down(quick_power_down),
    .complete_power_down(complete_power_down), .acquisition_active(acquisition_active),
    .converting(converting), .result_valid(result_valid), .result_data(result_data),
    .result_ready(result_ready));
  adcsc_host_model adcsc_host_model_inst (.clock(clock), .cs_n(cs_n), .sclk(sclk),
    .din(din), .dout(dout), .comparator_in(comparator_in));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // random odd half period, unrelated to the clock
  initial begin
    osc_half = 51 + 2 * ($unsigned($random(seed)) % 8);
    osc_in = 1'b0;
    forever #(osc_half) osc_in = ~osc_in;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // negedge sees what the next handshake edge takes
  always @(negedge clock) begin
    if (!srst && result_valid === 1'b1 && result_ready === 1'b1) begin
      check("result", 16'(result_data), exp_q.size() ? 16'(exp_q.pop_front()) : 16'hxxxx);
    end
  end
  // two zero bytes, control byte, two read bytes; internal mode waits for the strobe
  task automatic conv(input logic [7:0] ctrl, input logic [11:0] pat, input logic acc);
    logic [7:0] r2;
    logic [7:0] r3;
    int w;
    adcsc_host_model_inst.frame(1'b1);
    adcsc_host_model_inst.xfer(8'h00, 8'h00, r2);
    adcsc_host_model_inst.xfer(8'h00, 8'h00, r2);
    adcsc_host_model_inst.xfer(ctrl, {8{pat[11]}}, r2);
    if (acc && ctrl[1]) ext = ctrl[0];
    // internal mode hands the word over before the read bytes
    if (acc) exp_q.push_back(pat);
    if (acc && !ext) begin
      adcsc_host_model_inst.frame(1'b0);
      w = 0;
      while (conversion_strobe_out !== 1'b1 && w < 1000) begin
        @(posedge clock);
        w++;
      end
      check("strobe_oe", 16'(conversion_strobe_oe), 16'h1);
      check("strobe_wait", 16'(w > 0 && w < 1000), 16'h1);
      adcsc_host_model_inst.frame(1'b1);
    end
    adcsc_host_model_inst.xfer(8'h00, pat[11:4], r2);
    adcsc_host_model_inst.xfer(8'h00, {pat[3:0], 4'h0}, r3);
    adcsc_host_model_inst.frame(1'b0);
    check("frame", {r2, r3}, acc ? {1'b0, pat, 3'b000} : 16'h0);
    check("dout_oe", 16'(dout_oe), 16'h0);
    if (ext) check("strobe_oe", 16'(conversion_strobe_oe), 16'h0);
    if (acc) begin
      repeat (20) @(posedge clock);
      check("fields", 16'({ext_clock_mode, channel_select, polarity_select,
        input_config_select}), 16'({ext, ctrl[6:2]}));
      check("power_down", 16'({quick_power_down, complete_power_down}),
        16'({ctrl[1:0] == 2'h1, ctrl[1:0] == 2'h0}));
    end
  endtask
  initial begin
    logic [7:0] ctrl;
    logic [11:0] pat;
    logic [1:0] mode;
    logic sd;
    srst = 1'b1;
    shutdown_input_n = 1'b1; // high stands for a floating pin here
    result_ready = 1'b0;
    ext = 1'b0;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    check("power_on", 16'({conversion_strobe_out, conversion_strobe_oe, dout_oe,
      ext_clock_mode}), 16'hc);
    repeat (30) @(posedge clock);
    check("pd_idle", 16'({quick_power_down, complete_power_down}), 16'h0);
    // fill the fifo with the far side stalled; one more start is refused
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      mode = 2'($unsigned($random(seed)) % 3);
      if (mode == 2'h2 || i == 0) mode = 2'h3;
      pat = 12'($random(seed)) | 12'h801;
      ctrl = {1'b1, 5'($random(seed)), mode};
      conv(ctrl, pat, i < FIFO_DEPTH);
    end
    for (int k = 0; k < 2000 && exp_q.size() > 0; k++) begin
      @(posedge clock);
      result_ready <= 1'($random(seed));
    end
    @(posedge clock);
    result_ready <= 1'b1;
    check("drained", 16'(exp_q.size()), 16'h0);
    sd = 1'($random(seed));
    shutdown_input_n <= sd;
    repeat (10) @(posedge clock);
    if (!sd) check("idle_shutdown", 16'(complete_power_down), 16'h1);
    shutdown_input_n <= 1'b1;
    repeat (10) @(posedge clock);
    // acquisition length is analog and not modelled
    for (int j = 0; j < 3; j++) begin
      pat = {12{1'($random(seed))}};
      conv({1'b1, 5'($random(seed)), j < 2 ? 2'h2 : 2'h1}, pat, 1'b1);
    end
    conv(8'hff, 12'h5a5, 1'b1);
    adcsc_host_model_inst.frame(1'b1);
    adcsc_host_model_inst.xfer(8'hfe, 8'hff, ctrl); // internal run, cut by the pin
    @(posedge clock);
    shutdown_input_n <= 1'b0;
    repeat (10) @(posedge clock);
    check("shutdown", 16'({converting, complete_power_down}), 16'h1);
    shutdown_input_n <= 1'b1;
    adcsc_host_model_inst.frame(1'b0);
    repeat (50) @(posedge clock);
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge clock);
    n_fail++;
    finish_test();
  end
endmodule // adcsc_tb_top

// file: adcsc_top.sv
// serial command decoder and conversion sequencer with result fifo
// assumes all pins asynchronous; the serial clock is far slower than clock
// What this block and its host must do
// [RULE1] shift din on sclk rise while cs low
// [RULE2] skip leading zeros; first one starts byte
// [RULE3] conversion starts on fall after eighth bit
// [RULE4] dout changes on sclk falls only; strobe also on cs fall and internal conversion end
// [RULE5] result out msb first on falls
// [RULE6] external: strobe one period, 12 decisions follow
// [RULE7] frame: zero, twelve bits, three zeros
// [RULE8] external: tristate on cs high, low after fall
// [RULE9] host picks internal mode for slow clocks
// [RULE10] internal: strobe low while converting, then high
// [RULE11] internal: result held, msb on next fall
// [RULE12] cs high blocks input, tristates dout and, in external mode, the strobe
// [RULE13] start accepted idle or after bit three
// [RULE14] early start after cs fall aborts conversion
// [RULE15] host clocks sixteen zeros to resynchronise
// [RULE16] sampling during last three bits; mode bits
// [RULE17] power-on internal mode, strobe high, wait
// [RULE18] host uses clock polarity and phase zero
// [RULE19] host sends control byte then two zero bytes
// [RULE20] host keeps clock and transaction time limits
// [RULE21] internal compensation needs external mode, slow clock
// [RULE22] fast internal-mode shifting keeps acquisition time
// [RULE23] control byte fields decoded msb first
// [RULE24] mode bits select clock or power-down
// [RULE25] power-down after conversion; start bit wakes (code wakes at the fall after the eighth bit)
// [RULE26] shutdown low stops everything at once
// [RULE27] decisions from comparator, one per clock
// [RULE28] back to hunting after last result bit
`timescale 1ns/100ps

module adcsc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic ov_reg, ov_next;
  logic [WIDTH-1:0] od_reg, od_next;
  logic push, pop;

  // the output stage holds a word too, so it counts toward full
  assign in_ready = ((AW+1)'(cnt_reg + ov_reg) != (AW+1)'(DEPTH));
  assign out_valid = ov_reg;
  assign out_data = od_reg;

  always_comb begin
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    ov_next = ov_reg;
    od_next = od_reg;
    push = in_valid && in_ready;
    pop = (!ov_reg || out_ready) && (cnt_reg != '0);
    if (push) begin
      mem_next[wr_reg] = in_data;
      wr_next = AW'(wr_reg + 1'b1);
    end
    if (out_ready) begin
      ov_next = 1'b0;
    end
    if (pop) begin
      od_next = mem_reg[rd_reg];
      ov_next = 1'b1;
      rd_next = AW'(rd_reg + 1'b1);
    end
    cnt_next = (AW+1)'(cnt_reg + push - pop);
  end

  always_ff @(posedge clock) begin
    mem_reg <= mem_next;
    od_reg <= od_next;
    if (srst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      ov_reg <= 1'b0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      ov_reg <= ov_next;
    end
  end
endmodule // adcsc_fifo

module adcsc_top import adcsc_pkg::*; #(
  parameter int POR_WAIT = POR_CYCLES,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  output logic conversion_strobe_out,
  output logic conversion_strobe_oe,
  // converter pins
  input wire logic shutdown_input_n,
  input wire logic comparator_in,
  input wire logic osc_in,
  // status
  output logic [2:0] channel_select,
  output logic polarity_select,
  output logic input_config_select,
  output logic ext_clock_mode,
  output logic quick_power_down,
  output logic complete_power_down,
  output logic acquisition_active,
  output logic converting,
  // result stream
  output logic result_valid,
  output logic [RES_BITS-1:0] result_data,
  input wire logic result_ready
);
  // three-stage synchronisers, stages two and three must agree
  logic [ADCSC_NSYNC-1:0] pin_in, s1_reg, s2_reg, s3_reg, flt_reg, flt_next, prv_reg;
  assign pin_in = {osc_in, comparator_in, shutdown_input_n, din, sclk, cs_n};

  genvar g;
  generate
    for (g = 0; g < ADCSC_NSYNC; g++) begin : g_sync
      always_comb begin
        flt_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : flt_reg[g];
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    s1_reg <= pin_in;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    if (srst) begin
      // idle pin levels, so no false edge or shutdown follows reset
      flt_reg <= '0;
      flt_reg[SY_CS] <= 1'b1;
      flt_reg[SY_SHUTDOWN_INPUT] <= 1'b1;
      prv_reg <= '0;
      prv_reg[SY_CS] <= 1'b1;
      prv_reg[SY_SHUTDOWN_INPUT] <= 1'b1;
    end else begin
      flt_reg <= flt_next;
      prv_reg <= flt_reg;
    end
  end

  logic cs_low, cs_fall, rise, fall, din_s, shutdown_input_ok, comp_s, osc_rise;
  assign cs_low = !flt_reg[SY_CS];
  assign cs_fall = prv_reg[SY_CS] && !flt_reg[SY_CS];
  assign rise = !prv_reg[SY_SCLK] && flt_reg[SY_SCLK];
  assign fall = prv_reg[SY_SCLK] && !flt_reg[SY_SCLK];
  assign din_s = flt_reg[SY_DIN];
  assign shutdown_input_ok = flt_reg[SY_SHUTDOWN_INPUT];
  assign comp_s = flt_reg[SY_COMP];
  assign osc_rise = !prv_reg[SY_OSC] && flt_reg[SY_OSC];

  // sequencer state
  adcsc_state_t st_reg, st_next;
  logic rx_act_reg, rx_act_next, pend_reg, pend_next;
  logic [3:0] rx_cnt_reg, rx_cnt_next;
  logic [CTRL_BITS-1:0] rx_sh_reg, rx_sh_next, cb_reg, cb_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [RES_BITS-1:0] res_reg, res_next;
  logic ext_reg, ext_next, pdreq_reg, pdreq_next, pdf_reg, pdf_next;
  logic pd_reg, pd_next, full_reg, full_next;
  logic csf_reg, csf_next, b3_reg, b3_next;
  logic dout_reg, dout_next, doe_reg, doe_next, stb_reg, stb_next, soe_reg, soe_next;
  logic acq_reg, acq_next, push_reg, push_next;
  logic qpd_reg, qpd_next, cpd_reg, cpd_next, conv_reg, conv_next;
  logic [RES_BITS-1:0] pdat_reg, pdat_next;
  logic [31:0] por_reg, por_next;
  logic por_done, fifo_ready, accept;

  // a full buffer holds off new conversions rather than dropping a result
  assign por_done = (por_reg == 32'(POR_WAIT));
  assign accept = por_done && shutdown_input_ok && fifo_ready &&
                  (st_reg == ST_HUNT || b3_reg || csf_reg); // see [RULE13] see [RULE14]

  always_comb begin
    st_next = st_reg;
    rx_act_next = rx_act_reg;
    pend_next = pend_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_sh_next = rx_sh_reg;
    cb_next = cb_reg;
    cnt_next = cnt_reg;
    res_next = res_reg;
    ext_next = ext_reg;
    pdreq_next = pdreq_reg;
    pdf_next = pdf_reg;
    pd_next = pd_reg;
    full_next = full_reg;
    csf_next = csf_reg;
    b3_next = b3_reg;
    dout_next = dout_reg;
    stb_next = stb_reg;
    push_next = 1'b0;
    pdat_next = pdat_reg;
    por_next = por_done ? por_reg : por_reg + 32'h1; // see [RULE17]
    if (cs_fall) begin
      csf_next = 1'b1;
      if (ext_reg) begin
        stb_next = 1'b0; // see [RULE8]
      end
    end
    // control byte receiver; cs high blocks input
    if (rise && cs_low) begin // see [RULE1] see [RULE12]
      if (!rx_act_reg) begin
        if (din_s && accept) begin // see [RULE2]
          rx_act_next = 1'b1;
          rx_sh_next = {{(CTRL_BITS-1){1'b0}}, 1'b1};
          rx_cnt_next = RX_ONE;
        end
      end else begin
        rx_sh_next = {rx_sh_reg[CTRL_BITS-2:0], din_s};
        rx_cnt_next = 4'(rx_cnt_reg + 1'b1);
        if (4'(rx_cnt_reg + 1'b1) == RX_LAST) begin
          rx_act_next = 1'b0;
          pend_next = 1'b1;
          cb_next = {rx_sh_reg[CTRL_BITS-2:0], din_s};
        end
      end
    end
    if (fall && pend_reg) begin // see [RULE3] see [RULE14]
      pend_next = 1'b0;
      csf_next = cs_fall; // a select falling now still counts
      b3_next = 1'b0;
      cnt_next = '0;
      res_next = '0;
      pd_next = 1'b0; // see [RULE25]
      full_next = 1'b0;
      pdreq_next = !cb_reg[CB_PD1]; // see [RULE24]
      pdf_next = (cb_reg[CB_PD1:CB_PD0] == MODE_FAST_PD);
      // power-down codes keep the last clock mode for this conversion
      if (cb_reg[CB_PD1:CB_PD0] == MODE_EXT || cb_reg[CB_PD1:CB_PD0] == MODE_INT) begin
        ext_next = cb_reg[CB_PD0]; // see [RULE16]
      end
      if ((cb_reg[CB_PD1:CB_PD0] == MODE_EXT) ||
          (!cb_reg[CB_PD1] && ext_reg)) begin
        st_next = ST_EXT;
        stb_next = 1'b1; // see [RULE6]
        dout_next = 1'b0; // see [RULE7]
      end else begin
        st_next = ST_INT;
        stb_next = 1'b0; // see [RULE10]
        dout_next = 1'b0;
      end
    end else begin
      unique case (st_reg)
        ST_HUNT: begin
          if (fall) begin
            dout_next = 1'b0; // see [RULE17]
          end
        end
        ST_EXT: begin
          if (fall) begin // see [RULE4]
            cnt_next = 5'(cnt_reg + 1'b1);
            stb_next = 1'b0;
            if (cnt_reg < EXT_RES_LAST) begin
              dout_next = comp_s; // see [RULE27] see [RULE5] see [RULE6]
              res_next = {res_reg[RES_BITS-2:0], comp_s};
            end else begin
              dout_next = 1'b0; // see [RULE7]
            end
            if (5'(cnt_reg + 1'b1) == EXT_B3_FALL) begin
              b3_next = 1'b1;
            end
            if (5'(cnt_reg + 1'b1) == EXT_RES_LAST) begin
              push_next = 1'b1;
              pdat_next = {res_reg[RES_BITS-2:0], comp_s};
              pd_next = pdreq_reg;
              full_next = pdreq_reg && !pdf_reg;
            end
            if (5'(cnt_reg + 1'b1) == EXT_FALL_LAST) begin
              st_next = ST_HUNT; // see [RULE28]
            end
          end
        end
        ST_INT: begin
          // own conversion clock; cs high does not disturb it
          if (osc_rise) begin // see [RULE27] see [RULE12]
            res_next = {res_reg[RES_BITS-2:0], comp_s};
            cnt_next = 5'(cnt_reg + 1'b1);
            if (cnt_reg == SAR_LAST) begin
              st_next = ST_READ;
              cnt_next = '0;
              stb_next = 1'b1; // see [RULE10]
              push_next = 1'b1;
              pdat_next = {res_reg[RES_BITS-2:0], comp_s};
              pd_next = pdreq_reg; // see [RULE25]
              full_next = pdreq_reg && !pdf_reg;
            end
          end
        end
        ST_READ: begin
          if (fall) begin // see [RULE11] see [RULE5]
            dout_next = res_reg[RES_BITS-1];
            res_next = {res_reg[RES_BITS-2:0], 1'b0};
            cnt_next = 5'(cnt_reg + 1'b1);
            if (cnt_reg == RD_B3_FALL) begin
              b3_next = 1'b1;
            end
            if (cnt_reg == RD_LAST) begin
              st_next = ST_HUNT; // see [RULE28]
            end
          end
        end
      endcase
    end
    // the pin stops a conversion outright, no result is kept
    if (!shutdown_input_ok) begin // see [RULE26]
      st_next = ST_HUNT;
      rx_act_next = 1'b0;
      pend_next = 1'b0;
      pd_next = 1'b1;
      full_next = 1'b1;
      push_next = 1'b0;
    end
    acq_next = rx_act_next && (rx_cnt_next >= RX_ACQ_FIRST); // see [RULE16]
    qpd_next = pd_next && !full_next; // see [RULE25]
    cpd_next = pd_next && full_next; // see [RULE26]
    conv_next = (st_next == ST_EXT) || (st_next == ST_INT);
    doe_next = cs_low; // see [RULE12]
    soe_next = ext_next ? cs_low : 1'b1; // see [RULE8] see [RULE12]
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_reg <= ST_HUNT;
      rx_act_reg <= 1'b0;
      pend_reg <= 1'b0;
      rx_cnt_reg <= '0;
      rx_sh_reg <= '0;
      cb_reg <= '0;
      cnt_reg <= '0;
      res_reg <= '0;
      ext_reg <= 1'b0; // see [RULE17]
      pdreq_reg <= 1'b0;
      pdf_reg <= 1'b0;
      pd_reg <= 1'b0;
      full_reg <= 1'b0;
      csf_reg <= 1'b0;
      b3_reg <= 1'b0;
      dout_reg <= 1'b0;
      doe_reg <= 1'b0;
      stb_reg <= 1'b1; // see [RULE17]
      soe_reg <= 1'b1;
      acq_reg <= 1'b0;
      qpd_reg <= 1'b0;
      cpd_reg <= 1'b0;
      conv_reg <= 1'b0;
      push_reg <= 1'b0;
      pdat_reg <= '0;
      por_reg <= '0;
    end else begin
      st_reg <= st_next;
      rx_act_reg <= rx_act_next;
      pend_reg <= pend_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_sh_reg <= rx_sh_next;
      cb_reg <= cb_next;
      cnt_reg <= cnt_next;
      res_reg <= res_next;
      ext_reg <= ext_next;
      pdreq_reg <= pdreq_next;
      pdf_reg <= pdf_next;
      pd_reg <= pd_next;
      full_reg <= full_next;
      csf_reg <= csf_next;
      b3_reg <= b3_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      stb_reg <= stb_next;
      soe_reg <= soe_next;
      acq_reg <= acq_next;
      qpd_reg <= qpd_next;
      cpd_reg <= cpd_next;
      conv_reg <= conv_next;
      push_reg <= push_next;
      pdat_reg <= pdat_next;
      por_reg <= por_next;
    end
  end

  adcsc_fifo #(.WIDTH(RES_BITS), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .srst(srst),
    .in_valid(push_reg),
    .in_data(pdat_reg),
    .in_ready(fifo_ready),
    .out_valid(result_valid),
    .out_data(result_data),
    .out_ready(result_ready)
  );

  assign dout = dout_reg;
  assign dout_oe = doe_reg;
  assign conversion_strobe_out = stb_reg;
  assign conversion_strobe_oe = soe_reg;
  assign channel_select = cb_reg[CB_SEL_HI:CB_SEL_LO]; // see [RULE23]
  assign polarity_select = cb_reg[CB_POL];
  assign input_config_select = cb_reg[CB_CFG];
  assign ext_clock_mode = ext_reg;
  assign quick_power_down = qpd_reg;
  assign complete_power_down = cpd_reg;
  assign acquisition_active = acq_reg;
  assign converting = conv_reg;
endmodule // adcsc_top

// file: adcsc_top_assertions.sv
// checker for the serial conversion sequencer pins and result stream
// assumes host pins change on clock edges; device sees them a few clocks late
`timescale 1ns/100ps
module adcsc_top_assertions import adcsc_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic conversion_strobe_out,
  input wire logic conversion_strobe_oe,
  // converter and status
  input wire logic shutdown_input_n,
  input wire logic ext_clock_mode,
  input wire logic complete_power_down,
  input wire logic acquisition_active,
  input wire logic converting,
  // result stream
  input wire logic result_valid,
  input wire logic [RES_BITS-1:0] result_data,
  input wire logic result_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // clocks since the serial clock pin fell, saturating
  logic sclk_reg;
  logic [3:0] age_reg;
  logic [3:0] age_next;
  always_comb begin
    age_next = age_reg;
    if (sclk_reg && !sclk) age_next = 4'h0;
    else if (age_reg != 4'hf) age_next = age_reg + 4'h1;
  end
  always_ff @(posedge clock) begin
    sclk_reg <= sclk;
    age_reg <= srst ? 4'hf : age_next;
  end
  // margin of 9 covers synchroniser plus output register
  AST_DOUT_ON_FALL: assert property (
    $changed(dout) && shutdown_input_n |-> age_reg <= 4'h9)
    else $error("dout moved away from a serial clock fall");
  AST_DOUT_OE_CS: assert property (
    cs_n [*8] |-> !dout_oe) else $error("dout driven while deselected");
  AST_EXT_STROBE_HIZ: assert property (
    (cs_n && ext_clock_mode) [*8] |-> !conversion_strobe_oe)
    else $error("strobe driven while deselected in external mode");
  AST_INT_STROBE_DRIVEN: assert property (
    !ext_clock_mode [*3] |-> conversion_strobe_oe) else $error("strobe released in internal mode");
  AST_INT_STROBE_LOW: assert property (
    $rose(converting) && !ext_clock_mode |-> ##[0:2] !conversion_strobe_out)
    else $error("strobe not low at internal start");
  AST_INT_STROBE_END: assert property (
    $fell(converting) && !ext_clock_mode && shutdown_input_n |-> ##[0:2] conversion_strobe_out)
    else $error("strobe not high at internal end");
  AST_EXT_STROBE_PULSE: assert property (
    $rose(conversion_strobe_out) && ext_clock_mode |-> conversion_strobe_out [*8] ##1
    !conversion_strobe_out) else $error("external strobe pulse not one serial period");
  AST_SHUTDOWN_STOPS: assert property (
    !shutdown_input_n [*8] |-> !converting && complete_power_down)
    else $error("shutdown did not stop the converter");
  AST_ACQ_THEN_CONVERT: assert property (
    $rose(acquisition_active) && shutdown_input_n |-> ##[1:40] converting)
    else $error("no conversion after sampling phase");
  AST_RESULT_HOLD: assert property (
    result_valid && !result_ready |=> result_valid && $stable(result_data))
    else $error("result word dropped or changed while stalled");
  COV_EXT: cover property ($rose(converting) && ext_clock_mode);
  COV_INT: cover property ($rose(converting) && !ext_clock_mode);
  COV_STALL: cover property ((result_valid && !result_ready) [*8]);
endmodule // adcsc_top_assertions

bind adcsc_top adcsc_top_assertions adcsc_top_assertions_inst (
  .clock(clock), .srst(srst), .cs_n(cs_n), .sclk(sclk), .dout(dout), .dout_oe(dout_oe),
  .conversion_strobe_out(conversion_strobe_out), .conversion_strobe_oe(conversion_strobe_oe),
  .shutdown_input_n(shutdown_input_n), .ext_clock_mode(ext_clock_mode),
  .complete_power_down(complete_power_down), .acquisition_active(acquisition_active),
  .converting(converting), .result_valid(result_valid), .result_data(result_data),
  .result_ready(result_ready)
);
